//--- logic/cdu_pkg.sv
// constants for the converter update and data format block
// assumes an 8-bit special-function register space with page select
package cdu_pkg;
   // register addresses; page selects the channel copy
   localparam logic [7:0] CDU_ADDR_CONTROL   = 8'hD4;
   localparam logic [7:0] CDU_ADDR_DATA_LOW  = 8'hD2;
   localparam logic [7:0] CDU_ADDR_DATA_HIGH = 8'hD3;
   localparam logic [7:0] CDU_ADDR_REF_CTRL  = 8'hD1;
   localparam logic [7:0] CDU_PAGE_DEFAULT   = 8'h01;
   // control field positions
   localparam int CDU_BIT_ENABLE   = 7;
   localparam int CDU_MODE_HI      = 4;
   localparam int CDU_MODE_LO      = 3;
   localparam int CDU_FMT_HI       = 2;
   localparam int CDU_FMT_LO       = 0;
   localparam logic [7:0] CDU_CTRL_WMASK = 8'h9F;
   // reference control field positions
   localparam int CDU_BIT_TEMP     = 2;
   localparam int CDU_BIT_BIAS     = 1;
   localparam int CDU_BIT_REFBUF   = 0;
   localparam logic [7:0] CDU_REF_WMASK  = 8'h07;
   // reset values
   localparam logic [7:0]  CDU_RST_CTRL  = 8'h00;
   localparam logic [7:0]  CDU_RST_BYTE  = 8'h00;
   localparam logic [11:0] CDU_RST_LATCH = 12'h000;
   // update modes
   localparam logic [1:0] CDU_MODE_DEMAND = 2'h0;
   localparam logic [1:0] CDU_MODE_TMR3   = 2'h1;
   localparam logic [1:0] CDU_MODE_TMR4   = 2'h2;
   localparam logic [1:0] CDU_MODE_TMR2   = 2'h3;
endpackage : cdu_pkg

//--- logic/cdu_format.sv
// maps the 16-bit register pair onto the 12-bit converter word
// assumes format code from the control register, purely combinational
`timescale 1ns/1ns
module cdu_format (
   input  wire logic [2:0]  i_fmt,
   input  wire logic [7:0]  i_high,
   input  wire logic [7:0]  i_low,
   output logic      [11:0] o_word
);
   import cdu_pkg::*;

   // alignment select; top format bit forces byte alignment
   always_comb begin
      if (i_fmt[2]) begin
         o_word = {i_high, i_low[7:4]};
      end else begin
         unique case (i_fmt[1:0])
            2'h0: o_word = {i_high[3:0], i_low};
            2'h1: o_word = {i_high[4:0], i_low[7:1]};
            2'h2: o_word = {i_high[5:0], i_low[7:2]};
            2'h3: o_word = {i_high[6:0], i_low[7:3]};
         endcase
      end
   end
endmodule // cdu_format

//--- logic/cdu_top.sv
// converter channel control: enable, update scheduling, data format
// assumes one-cycle register strobes from the core and one-cycle timer overflow pulses
`timescale 1ns/1ns
module cdu_top #(
   parameter logic [7:0] PAGE = cdu_pkg::CDU_PAGE_DEFAULT
) (
   input  wire logic        i_mclk,
   input  wire logic        i_sys_rst,
   input  wire logic [7:0]  i_sfr_addr,
   input  wire logic [7:0]  i_sfr_page,
   input  wire logic        i_sfr_wr,
   input  wire logic        i_sfr_rd,
   input  wire logic [7:0]  i_sfr_wdata,
   input  wire logic        i_tmr2_ovf,
   input  wire logic        i_tmr3_ovf,
   input  wire logic        i_tmr4_ovf,
   output logic      [7:0]  o_sfr_rdata,
   output logic             o_sfr_hit,
   output logic      [11:0] o_conv_latch,
   output logic             o_conv_enable,
   output logic             o_conv_shutdown,
   output logic             o_conv_out_en,
   output logic             o_bias_gen_enable,
   output logic             o_ref_buffer_enable,
   output logic             o_ref_pin_oe,
   output logic             o_temp_sensor_enable
);
   import cdu_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   function automatic logic hit(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] want);
      hit = (pg == PAGE) && (a == want);
   endfunction

   logic wr_ctrl, wr_low, wr_high, wr_ref;
   assign wr_ctrl = i_sfr_wr && hit(i_sfr_addr, i_sfr_page, CDU_ADDR_CONTROL);
   assign wr_low  = i_sfr_wr && hit(i_sfr_addr, i_sfr_page, CDU_ADDR_DATA_LOW);
   assign wr_high = i_sfr_wr && hit(i_sfr_addr, i_sfr_page, CDU_ADDR_DATA_HIGH);
   assign wr_ref  = i_sfr_wr && hit(i_sfr_addr, i_sfr_page, CDU_ADDR_REF_CTRL);

   ////////////////////////////////////////////////////////////////////////////
   // register state

   logic [7:0]  ctrl_q, ctrl_d;
   logic [7:0]  low_q, low_d;
   logic [7:0]  high_q, high_d;
   logic [7:0]  ref_q, ref_d;
   logic [11:0] latch_q, latch_d;
   logic [11:0] fmt_word;
   logic [1:0]  mode;
   logic        upd;

   assign mode = ctrl_q[CDU_MODE_HI:CDU_MODE_LO];

   // formatted word of what would sit in the registers after this cycle
   cdu_format u_format (
      .i_fmt  (ctrl_q[CDU_FMT_HI:CDU_FMT_LO]),
      .i_high (high_d),
      .i_low  (low_d),
      .o_word (fmt_word)
   );

   // update trigger; high-byte write in demand mode, chosen overflow otherwise
   always_comb begin
      unique case (mode)
         CDU_MODE_DEMAND: upd = wr_high;
         CDU_MODE_TMR3:   upd = i_tmr3_ovf;
         CDU_MODE_TMR4:   upd = i_tmr4_ovf;
         CDU_MODE_TMR2:   upd = i_tmr2_ovf;
      endcase
   end

   // next values; a write landing with an overflow is included in the copy
   always_comb begin
      ctrl_d  = wr_ctrl ? (i_sfr_wdata & CDU_CTRL_WMASK) : ctrl_q;
      low_d   = wr_low  ? i_sfr_wdata : low_q;
      high_d  = wr_high ? i_sfr_wdata : high_q;
      ref_d   = wr_ref  ? (i_sfr_wdata & CDU_REF_WMASK) : ref_q;
      latch_d = upd ? fmt_word : latch_q;
   end

   // registers; reset gives disabled, demand mode, nibble format
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         ctrl_q  <= CDU_RST_CTRL;
         low_q   <= CDU_RST_BYTE;
         high_q  <= CDU_RST_BYTE;
         ref_q   <= CDU_RST_CTRL;
         latch_q <= CDU_RST_LATCH;
      end else begin
         ctrl_q  <= ctrl_d;
         low_q   <= low_d;
         high_q  <= high_d;
         ref_q   <= ref_d;
         latch_q <= latch_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path; data bytes return held values, not the latch

   always_comb begin
      o_sfr_hit   = 1'b1;
      o_sfr_rdata = 8'h00;
      if (!i_sfr_rd) begin
         o_sfr_hit = 1'b0;
      end else if (hit(i_sfr_addr, i_sfr_page, CDU_ADDR_CONTROL)) begin
         o_sfr_rdata = ctrl_q;
      end else if (hit(i_sfr_addr, i_sfr_page, CDU_ADDR_DATA_LOW)) begin
         o_sfr_rdata = low_q;
      end else if (hit(i_sfr_addr, i_sfr_page, CDU_ADDR_DATA_HIGH)) begin
         o_sfr_rdata = high_q;
      end else if (hit(i_sfr_addr, i_sfr_page, CDU_ADDR_REF_CTRL)) begin
         o_sfr_rdata = ref_q;
      end else begin
         o_sfr_hit = 1'b0;                          // other blocks answer
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // analog controls; bias and buffer are software's duty to set correctly

   assign o_conv_latch         = latch_q;
   assign o_conv_enable        = ctrl_q[CDU_BIT_ENABLE];
   assign o_conv_shutdown      = !ctrl_q[CDU_BIT_ENABLE];
   assign o_conv_out_en        = ctrl_q[CDU_BIT_ENABLE];
   assign o_bias_gen_enable    = ref_q[CDU_BIT_BIAS];
   assign o_ref_buffer_enable  = ref_q[CDU_BIT_REFBUF];
   assign o_ref_pin_oe         = ref_q[CDU_BIT_REFBUF];
   assign o_temp_sensor_enable = ref_q[CDU_BIT_TEMP];

   ////////////////////////////////////////////////////////////////////////////
   // checks

   a_unused_read_zero: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      ctrl_q[6:5] == 2'h0) else $error("unused control bits not zero");

   a_demand_high_update: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (mode == CDU_MODE_DEMAND && wr_high && !wr_ctrl) |=> (latch_q == $past(fmt_word)))
      else $error("high write did not update latch");

   a_low_write_hold: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (mode == CDU_MODE_DEMAND && !wr_high) |=> $stable(latch_q))
      else $error("latch changed without high write");

   a_timer3_update: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (mode == CDU_MODE_TMR3 && i_tmr3_ovf) |=> (latch_q == $past(fmt_word)))
      else $error("timer 3 overflow missed");

   a_timer_hold: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (mode != CDU_MODE_DEMAND && !upd) |=> $stable(latch_q))
      else $error("latch changed without overflow");

   a_enable_outputs: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (wr_ctrl && !i_sfr_wdata[7]) |=> (o_conv_shutdown && !o_conv_out_en))
      else $error("disable did not shut converter");

   a_byte_fmt: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      ctrl_q[2] |-> (fmt_word[3:0] == low_d[7:4] && fmt_word[11:4] == high_d))
      else $error("byte format wrong");

   a_read_low: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      wr_low ##1 !wr_low ##1 (i_sfr_rd && hit(i_sfr_addr, i_sfr_page, CDU_ADDR_DATA_LOW) && !wr_low)
      |-> o_sfr_rdata == $past(i_sfr_wdata, 2)) else $error("low read mismatch");

   a_reset_state: assert property (@(posedge i_mclk)
      $past(i_sys_rst) |-> (latch_q == 12'h000 && ctrl_q == 8'h00))
      else $error("reset state wrong");

   ////////////////////////////////////////////////////////////////////////////
   // checks: update scheduling

   // mode 10 copies the word on timer 4 overflow
   a_timer4_update: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (mode == CDU_MODE_TMR4 && i_tmr4_ovf) |=> (latch_q == $past(fmt_word)))
      else $error("timer 4 overflow missed");

   // mode 11 copies the word on timer 2 overflow
   a_timer2_update: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (mode == CDU_MODE_TMR2 && i_tmr2_ovf) |=> (latch_q == $past(fmt_word)))
      else $error("timer 2 overflow missed");

   // overflows are ignored while updates follow high byte writes
   a_demand_no_timer: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (mode == CDU_MODE_DEMAND && !wr_high && (i_tmr2_ovf || i_tmr3_ovf || i_tmr4_ovf)) |=> $stable(latch_q))
      else $error("overflow moved latch in demand mode");

   // byte writes in a timer mode wait for the overflow
   a_timer_write_held: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (mode != CDU_MODE_DEMAND && (wr_low || wr_high) && !upd) |=> $stable(latch_q))
      else $error("byte write reached latch in timer mode");

   ////////////////////////////////////////////////////////////////////////////
   // checks: enable and control register

   // setting the enable wakes the converter and its output pin
   a_enable_on: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (wr_ctrl && i_sfr_wdata[CDU_BIT_ENABLE]) |=> (o_conv_enable && o_conv_out_en && !o_conv_shutdown))
      else $error("enable did not wake converter");

   // output pin and shutdown always agree with the enable bit
   a_enable_pins: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (o_conv_out_en == o_conv_enable) && (o_conv_shutdown == !o_conv_enable))
      else $error("enable outputs disagree");

   // a control write keeps only the implemented bits
   a_ctrl_write_mask: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      wr_ctrl |=> (ctrl_q == ($past(i_sfr_wdata) & CDU_CTRL_WMASK)))
      else $error("control write not masked");

   // unused control bits read back as zero
   a_ctrl_read_zero: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_sfr_rd && hit(i_sfr_addr, i_sfr_page, CDU_ADDR_CONTROL)) |-> (o_sfr_rdata[6:5] == 2'h0))
      else $error("unused control bits read nonzero");

   ////////////////////////////////////////////////////////////////////////////
   // checks: data bytes and read path

   // low byte takes all eight written bits
   a_low_write_land: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      wr_low |=> (low_q == $past(i_sfr_wdata)))
      else $error("low byte write lost");

   // high byte holds the written value whatever the mode
   a_high_write_land: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      wr_high |=> (high_q == $past(i_sfr_wdata)))
      else $error("high byte write lost");

   // a read of the high byte returns what was written, not the latch
   a_read_high: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      wr_high ##1 !wr_high ##1 (i_sfr_rd && hit(i_sfr_addr, i_sfr_page, CDU_ADDR_DATA_HIGH) && !wr_high)
      |-> o_sfr_rdata == $past(i_sfr_wdata, 2)) else $error("high read mismatch");

   // data bytes hold between writes
   a_bytes_hold: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (!wr_low && !wr_high) |=> ($stable(low_q) && $stable(high_q)))
      else $error("data byte changed without write");

   // no read strobe, no answer; other blocks share the read bus
   a_idle_read: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      !i_sfr_rd |-> (!o_sfr_hit && o_sfr_rdata == 8'h00))
      else $error("read path active without strobe");

   ////////////////////////////////////////////////////////////////////////////
   // checks: word alignment

   // format 000: nibble of the high byte over the whole low byte
   a_fmt_nibble: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (ctrl_q[CDU_FMT_HI:CDU_FMT_LO] == 3'h0) |-> (fmt_word == {high_d[3:0], low_d}))
      else $error("format 000 wrong");

   // format 001: five high bits, seven low bits
   a_fmt_five: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (ctrl_q[CDU_FMT_HI:CDU_FMT_LO] == 3'h1) |-> (fmt_word == {high_d[4:0], low_d[7:1]}))
      else $error("format 001 wrong");

   // format 010: six high bits, six low bits
   a_fmt_six: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (ctrl_q[CDU_FMT_HI:CDU_FMT_LO] == 3'h2) |-> (fmt_word == {high_d[5:0], low_d[7:2]}))
      else $error("format 010 wrong");

   // format 011: seven high bits, five low bits
   a_fmt_seven: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (ctrl_q[CDU_FMT_HI:CDU_FMT_LO] == 3'h3) |-> (fmt_word == {high_d[6:0], low_d[7:3]}))
      else $error("format 011 wrong");

   ////////////////////////////////////////////////////////////////////////////
   // checks: reference control

   // bias bit follows the last reference control write
   a_bias_write: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      wr_ref |=> (o_bias_gen_enable == $past(i_sfr_wdata[CDU_BIT_BIAS])))
      else $error("bias enable wrong");

   // buffer bit follows the last reference control write
   a_buffer_write: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      wr_ref |=> (o_ref_buffer_enable == $past(i_sfr_wdata[CDU_BIT_REFBUF])))
      else $error("buffer enable wrong");

   // reference pin floats whenever the buffer is off
   a_refpin_float: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      !o_ref_buffer_enable |-> !o_ref_pin_oe)
      else $error("reference pin driven with buffer off");

   ////////////////////////////////////////////////////////////////////////////
   // checks: reset defaults

   // a reset edge leaves a zero latch, a sleeping channel, demand mode and nibble format
   a_reset_outputs: assert property (@(posedge i_mclk)
      i_sys_rst |=> (o_conv_latch == CDU_RST_LATCH && o_conv_shutdown && !o_conv_out_en
         && mode == CDU_MODE_DEMAND && ctrl_q[CDU_FMT_HI:CDU_FMT_LO] == 3'h0))
      else $error("reset defaults wrong");
endmodule // cdu_top

//--- tb/cdu_partner.sv
// core and timer model: register strobes, read sampling, overflow pulses
// assumes callers sit in the i_mclk domain; drives just after rising edges
`timescale 1ns/1ns
module cdu_partner (
   input  wire logic       i_mclk,
   input  wire logic [7:0] i_rdata,
   input  wire logic       i_hit,
   output logic      [7:0] o_addr,
   output logic            o_wr,
   output logic            o_rd,
   output logic      [7:0] o_wdata,
   output logic      [2:0] o_ovf
);
   ////////////////////////////////////////
   // hit flag seen at the edge that took the last read data
   logic hit_seen;
   // idle bus; ovf[0] timer 2, [1] timer 3, [2] timer 4
   initial begin
      hit_seen = 1'b0;
      o_addr = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 8'h00;
      o_ovf = 3'h0;
   end
   // one-cycle write; data inverted after release so stale bytes never pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      #1 o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(posedge i_mclk);
      #1 o_wr = 1'b0;
      o_wdata = ~d;
   endtask
   // read data taken at the edge that ends the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_mclk);
      #1 o_addr = a;
      o_rd = 1'b1;
      @(posedge i_mclk);
      d = i_rdata;
      hit_seen = i_hit;
      #1 o_rd = 1'b0;
   endtask
   task automatic ovf(input int n);
      @(posedge i_mclk);
      #1 o_ovf[n] = 1'b1;
      @(posedge i_mclk);
      #1 o_ovf = 3'h0;
   endtask
endmodule // cdu_partner

//--- tb/cdu_top_bench.sv
// bench for cdu_top: reset state, registers, formats, update modes
// assumes cdu_partner plays the core; page input tied to the default page
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module cdu_top_bench;
   import cdu_pkg::*;
   logic        i_mclk, i_sys_rst, wr, rd, hit, en, sd, oe, bias, rbuf, rpin, temp;
   logic [7:0]  addr, wdata, rdata, d;
   logic [2:0]  ovf;
   logic [11:0] latch, prev;
   int          n_fail, comparisons;
   ////////////////////////////////////////
   cdu_partner u_p (.i_mclk(i_mclk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd),
      .o_wdata(wdata), .o_ovf(ovf), .i_hit(hit));
   cdu_top u_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_sfr_addr(addr), .i_sfr_page(CDU_PAGE_DEFAULT),
      .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata), .i_tmr2_ovf(ovf[0]), .i_tmr3_ovf(ovf[1]),
      .i_tmr4_ovf(ovf[2]), .o_sfr_rdata(rdata), .o_sfr_hit(hit), .o_conv_latch(latch), .o_conv_enable(en),
      .o_conv_shutdown(sd), .o_conv_out_en(oe), .o_bias_gen_enable(bias), .o_ref_buffer_enable(rbuf),
      .o_ref_pin_oe(rpin), .o_temp_sensor_enable(temp));
   ////////////////////////////////////////
   // expected word, worked out independently of the design
   function automatic logic [11:0] fmtw(input logic [2:0] f, input logic [7:0] h, input logic [7:0] l);
      case (f)
         3'h0: fmtw = {h[3:0], l};
         3'h1: fmtw = {h[4:0], l[7:1]};
         3'h2: fmtw = {h[5:0], l[7:2]};
         3'h3: fmtw = {h[6:0], l[7:3]};
         default: fmtw = {h, l[7:4]};
      endcase
   endfunction
   task automatic t_reset();
      `CHK("latch", 12'h000, latch)
      `CHK("shutdown", 1'b1, sd)
      `CHK("out_en", 1'b0, oe)
      `CHK("enable", 1'b0, en)
      u_p.rd(CDU_ADDR_CONTROL, d);
      `CHK("control", 8'h00, d)
   endtask
   // bias set before any converter use; buffer only with internal reference
   task automatic t_ref();
      u_p.wr(CDU_ADDR_REF_CTRL, 8'hFE);
      `CHK("bias", 1'b1, bias)
      `CHK("ref pin oe", 1'b0, rpin)
      `CHK("temp", 1'b1, temp)
      u_p.wr(CDU_ADDR_REF_CTRL, 8'h03);
      `CHK("buffer", 1'b1, rbuf)
      `CHK("ref pin oe", 1'b1, rpin)
      `CHK("temp", 1'b0, temp)
   endtask
   task automatic t_control();
      u_p.wr(CDU_ADDR_CONTROL, 8'hFF);
      u_p.rd(CDU_ADDR_CONTROL, d);
      `CHK("control", 8'h9F, d)
      `CHK("hit", 1'b1, u_p.hit_seen)
      `CHK("shutdown", 1'b0, sd)
      `CHK("out_en", 1'b1, oe)
      `CHK("enable", 1'b1, en)
      u_p.rd(8'h00, d);
      `CHK("unmapped", 8'h00, d)
      `CHK("hit unmapped", 1'b0, u_p.hit_seen)
   endtask
   // every format code, low byte held until the high write
   task automatic t_format();
      logic [7:0] l;
      for (int f = 0; f < 8; f++) begin
         l = 8'h6D ^ 8'(f << 5);
         u_p.wr(CDU_ADDR_CONTROL, 8'h80 | 8'(f));
         prev = latch;
         u_p.wr(CDU_ADDR_DATA_LOW, l);
         `CHK("latch held", prev, latch)
         u_p.rd(CDU_ADDR_DATA_LOW, d);
         `CHK("low readback", l, d)
         u_p.wr(CDU_ADDR_DATA_HIGH, 8'hB7);
         `CHK("latch", fmtw(3'(f), 8'hB7, l), latch)
      end
   endtask
   // timer modes: wrong timer first, then the selected one
   task automatic t_timer();
      logic [7:0] h;
      for (int i = 1; i < 4; i++) begin
         h = 8'h20 + 8'(i);
         u_p.wr(CDU_ADDR_CONTROL, {3'h4, 2'(i), 3'h4});
         prev = latch;
         u_p.wr(CDU_ADDR_DATA_LOW, 8'(i << 4));
         u_p.wr(CDU_ADDR_DATA_HIGH, h);
         `CHK("latch held", prev, latch)
         u_p.rd(CDU_ADDR_DATA_HIGH, d);
         `CHK("high readback", h, d)
         u_p.ovf((i + 1) % 3);
         `CHK("latch other timer", prev, latch)
         u_p.ovf(i % 3);
         `CHK("latch", {h, 4'(i)}, latch)
      end
   endtask
   // reset in mid-run restores defaults; a timer 3 overflow then ignored in demand mode
   task automatic t_rerun();
      @(posedge i_mclk);
      #1 i_sys_rst = 1'b1;
      repeat (2) @(posedge i_mclk);
      #1 i_sys_rst = 1'b0;
      `CHK("latch after reset", 12'h000, latch)
      `CHK("shutdown after reset", 1'b1, sd)
      `CHK("bias after reset", 1'b0, bias)
      u_p.rd(CDU_ADDR_DATA_HIGH, d);
      `CHK("high after reset", 8'h00, d)
      u_p.ovf(1);
      `CHK("latch demand ovf", 12'h000, latch)
      u_p.wr(CDU_ADDR_DATA_HIGH, 8'h5C);
      `CHK("latch nibble", 12'hC00, latch)
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      i_mclk = 1'b0;
      forever #4 i_mclk = ~i_mclk;
   end
   // watchdog: whole run needs well under 100 us
   initial begin
      #100000;
      n_fail++;
      finish_test();
   end
   initial begin
      i_sys_rst = 1'b1;
      n_fail = 0;
      comparisons = 0;
      repeat (12) @(posedge i_mclk);
      #1 i_sys_rst = 1'b0;
      t_reset();
      t_ref();
      t_control();
      t_format();
      t_timer();
      t_rerun();
      finish_test();
   end
endmodule // cdu_top_bench
